/* File: rtl/rpb_radio_bank.sv */
// radio amplifier, rssi offset and two-line interrupt enable register bank
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`include "rpb_params.svh"

module rpb_radio_bank #(
   parameter int RSSI_W = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // radio side
   input wire rpb_pkg::rpb_events_t events,
   input wire logic [5:0] convCode,
   input wire logic [RSSI_W-1:0] rssiRaw,
   output rpb_pkg::rpb_amp_t amp,
   output logic [RSSI_W-1:0] rssiReported,
   // interrupt lines
   output logic irqLine1,
   output logic irqLine2
);
   import rpb_pkg::*;

   rpb_state_t s_q;
   rpb_state_t s_d;

   logic access;
   logic done;
   logic hit;
   logic [9:0] idx;
   logic [7:0] rdByte;
   logic [7:0] sysClr;
   logic [7:0] pktClr;
   logic [7:0] wrByte;

   assign idx = paddr[11:2];
   assign access = psel && penable;
   assign done = access && (s_q.phase == RPB_PH_ANSWER);
   assign wrByte = pwdata[7:0];

   // read mux, narrow data in the low bits
   always_comb begin
      hit = 1'b1;
      rdByte = 8'h00;
      case (idx)
         `RPB_IDX_EXT_AMP: begin
            rdByte = s_q.extAmp;
         end
         `RPB_IDX_CONV_RBK: begin
            rdByte = {2'h0, convCode};
         end
         `RPB_IDX_GAIN_CFG5: begin
            rdByte = s_q.gainCfg5;
         end
         `RPB_IDX_L1_SYS_EN: begin
            rdByte = s_q.l1SysEn;
         end
         `RPB_IDX_L1_PKT_EN: begin
            rdByte = s_q.l1PktEn;
         end
         `RPB_IDX_L2_SYS_EN: begin
            rdByte = s_q.l2SysEn;
         end
         `RPB_IDX_L2_PKT_EN: begin
            rdByte = s_q.l2PktEn;
         end
         `RPB_IDX_SYS_STAT: begin
            rdByte = s_q.stat.sys;
         end
         `RPB_IDX_PKT_STAT: begin
            rdByte = s_q.stat.pkt;
         end
         `RPB_IDX_RSSI_RBK: begin
            rdByte = s_q.rssiOut[7:0];
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end

   // decode of the interface mode into pin behaviour
   function automatic rpb_amp_t ampDecode(input logic [7:0] cfg);
      rpb_amp_t a;
      a.level = cfg[`RPB_LEVEL_LSB +: 4];
      a.bandgapRef = cfg[`RPB_BIAS_SRC_BIT];
      a.supplyOn = 1'b1;
      a.biasPin = RPB_BIAS_FLOAT;
      case (cfg[2:0])
         3'h0: begin
            a.biasPin = RPB_BIAS_FLOAT;
         end
         3'h1: begin
            a.biasPin = RPB_BIAS_SOURCE;
         end
         3'h2: begin
            a.biasPin = RPB_BIAS_SINK;
         end
         3'h3: begin
            a.supplyOn = 1'b0;
            a.biasPin = RPB_BIAS_SOURCE;
         end
         3'h4: begin
            a.supplyOn = 1'b0;
            a.biasPin = RPB_BIAS_SINK;
         end
         3'h5: begin
            a.biasPin = RPB_BIAS_SERVO_POS;
         end
         3'h6: begin
            a.biasPin = RPB_BIAS_SERVO_NEG;
         end
         default: begin
            // reserved code: safest is supply on, bias pin floating
            a.biasPin = RPB_BIAS_FLOAT;
         end
      endcase
      return a;
   endfunction

   always_comb begin
      s_d = s_q;
      sysClr = 8'h00;
      pktClr = 8'h00;
      // answer one cycle into the access phase so prdata comes from a flop
      if (access && (s_q.phase == RPB_PH_IDLE)) begin
         s_d.phase = RPB_PH_ANSWER;
         s_d.prdata = {24'h000000, rdByte};
         s_d.pslverr = !hit;
      end else begin
         s_d.phase = RPB_PH_IDLE;
         s_d.pslverr = 1'b0;
      end
      if (done && pwrite) begin
         case (idx)
            `RPB_IDX_EXT_AMP: begin
               s_d.extAmp = wrByte;
            end
            `RPB_IDX_GAIN_CFG5: begin
               s_d.gainCfg5 = wrByte;
            end
            `RPB_IDX_L1_SYS_EN: begin
               s_d.l1SysEn = wrByte & `RPB_SYS_EN_MASK;
            end
            `RPB_IDX_L1_PKT_EN: begin
               s_d.l1PktEn = wrByte & `RPB_PKT_EN_MASK;
            end
            `RPB_IDX_L2_SYS_EN: begin
               s_d.l2SysEn = wrByte & `RPB_SYS_EN_MASK;
            end
            `RPB_IDX_L2_PKT_EN: begin
               s_d.l2PktEn = wrByte & `RPB_PKT_EN_MASK;
            end
            default: begin
            end
         endcase
      end
      // read clears only the bits that were reported, so none is lost
      if (done && !pwrite && (idx == `RPB_IDX_SYS_STAT)) begin
         sysClr = s_q.prdata[7:0];
      end
      if (done && !pwrite && (idx == `RPB_IDX_PKT_STAT)) begin
         pktClr = s_q.prdata[7:0];
      end
      // a new event wins over the clear
      s_d.stat.sys = (s_q.stat.sys & ~sysClr) | (events.sys & `RPB_SYS_EN_MASK);
      s_d.stat.pkt = (s_q.stat.pkt & ~pktClr) | (events.pkt & `RPB_PKT_EN_MASK);
      s_d.rssiOut = rssiRaw
         + RSSI_W'(s_q.gainCfg5[`RPB_RSSI_OFFS_LSB +: 3]);
      s_d.amp = ampDecode(s_d.extAmp);
      s_d.irq1 = |(s_d.stat.sys & s_d.l1SysEn)
         || |(s_d.stat.pkt & s_d.l1PktEn);
      s_d.irq2 = |(s_d.stat.sys & s_d.l2SysEn)
         || |(s_d.stat.pkt & s_d.l2PktEn);
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s_q.phase <= RPB_PH_IDLE;
         s_q.prdata <= 32'h00000000;
         s_q.pslverr <= 1'b0;
         s_q.extAmp <= `RPB_RST_EXT_AMP;
         s_q.gainCfg5 <= `RPB_RST_GAIN_CFG5;
         s_q.l1SysEn <= `RPB_RST_SYS_EN;
         s_q.l1PktEn <= `RPB_RST_PKT_EN;
         s_q.l2SysEn <= `RPB_RST_SYS_EN;
         s_q.l2PktEn <= `RPB_RST_PKT_EN;
         s_q.stat <= '0;
         s_q.rssiOut <= '0;
         s_q.amp <= {4'hF, 1'b0, 1'b1, RPB_BIAS_SOURCE};
         s_q.irq1 <= 1'b0;
         s_q.irq2 <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.prdata;
   assign pready = (s_q.phase == RPB_PH_ANSWER);
   assign pslverr = s_q.pslverr;
   assign amp = s_q.amp;
   assign rssiReported = s_q.rssiOut;
   assign irqLine1 = s_q.irq1;
   assign irqLine2 = s_q.irq2;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   sequence s_setup;
      psel && !penable;
   endsequence

   sequence s_first_access;
      psel && penable && !pready;
   endsequence

   property p_answer_next;
      s_first_access |=> pready;
   endproperty
   a_answer_next: assert property (p_answer_next)
      else $error("pready not raised one cycle into access");

   property p_ready_one_cycle;
      pready |=> !pready;
   endproperty
   a_ready_one_cycle: assert property (p_ready_one_cycle)
      else $error("pready held longer than one cycle");

   property p_level_follows;
      psel && penable && pready && pwrite
         && (idx == `RPB_IDX_EXT_AMP)
      |=> ##1 amp.level == $past(pwdata[7:4], 2);
   endproperty
   a_level_follows: assert property (p_level_follows)
      else $error("amplifier level does not follow write");

   property p_bias_src;
      amp.bandgapRef == s_q.extAmp[`RPB_BIAS_SRC_BIT];
   endproperty
   a_bias_src: assert property (p_bias_src)
      else $error("bias source select wrong");

   property p_servo_supply;
      (s_q.extAmp[2:0] == 3'h5) ##1 (s_q.extAmp[2:0] == 3'h5)
      |-> amp.supplyOn && amp.biasPin == RPB_BIAS_SERVO_POS;
   endproperty
   a_servo_supply: assert property (p_servo_supply)
      else $error("servo mode 5 pins wrong");

   property p_low_modes_off;
      s_q.extAmp[2:0] inside {3'h3, 3'h4} |-> !amp.supplyOn;
   endproperty
   a_low_modes_off: assert property (p_low_modes_off)
      else $error("supply switch not off in modes 3 and 4");

   property p_rssi_sum;
      !$past(reset) |-> rssiReported == RSSI_W'($past(rssiRaw)
         + RSSI_W'($past(s_q.gainCfg5[4:2])));
   endproperty
   a_rssi_sum: assert property (p_rssi_sum)
      else $error("rssi readback offset not applied");

   property p_conv_read;
      s_setup ##1 (s_first_access and (!pwrite
         && idx == `RPB_IDX_CONV_RBK))
      |=> prdata[7:6] == 2'h0 && prdata[5:0] == $past(convCode);
   endproperty
   a_conv_read: assert property (p_conv_read)
      else $error("converter readback wrong");

   property p_cmd_irq;
      events.sys[`RPB_SYS_CMD_ACCEPT] && s_q.l1SysEn[`RPB_SYS_CMD_ACCEPT]
      |=> irqLine1;
   endproperty
   a_cmd_irq: assert property (p_cmd_irq)
      else $error("command accept event did not raise line one");

   property p_ready_line2;
      events.sys[`RPB_SYS_READY] && s_q.l2SysEn[`RPB_SYS_READY]
      |=> irqLine2;
   endproperty
   a_ready_line2: assert property (p_ready_line2)
      else $error("ready event did not raise line two");

   property p_tx_irq1;
      events.pkt[`RPB_PKT_TX_DONE] && s_q.l1PktEn[`RPB_PKT_TX_DONE]
      |=> irqLine1;
   endproperty
   a_tx_irq1: assert property (p_tx_irq1)
      else $error("tx complete event did not raise line one");

   property p_delim_irq1;
      events.pkt[`RPB_PKT_DELIM_TX] && s_q.l1PktEn[`RPB_PKT_DELIM_TX]
      |=> irqLine1;
   endproperty
   a_delim_irq1: assert property (p_delim_irq1)
      else $error("delimiter sent event did not raise line one");

   property p_sys_read_clears;
      pready && !pwrite && idx == `RPB_IDX_SYS_STAT
         && events.sys == 8'h00
      |=> (s_q.stat.sys & $past(prdata[7:0])) == 8'h00;
   endproperty
   a_sys_read_clears: assert property (p_sys_read_clears)
      else $error("system status bits not cleared by read");

   property p_pkt_read_clears;
      pready && !pwrite && idx == `RPB_IDX_PKT_STAT
         && events.pkt == 8'h00
      |=> (s_q.stat.pkt & $past(prdata[7:0])) == 8'h00;
   endproperty
   a_pkt_read_clears: assert property (p_pkt_read_clears)
      else $error("packet status bits not cleared by read");

   property p_rx_irq2;
      events.pkt[`RPB_PKT_RX_DONE] && s_q.l2PktEn[`RPB_PKT_RX_DONE]
      |=> irqLine2 [*2];
   endproperty
   a_rx_irq2: assert property (p_rx_irq2)
      else $error("rx event did not hold line two");

   property p_cca_sticky;
      events.pkt[`RPB_PKT_CCA] |=> s_q.stat.pkt[`RPB_PKT_CCA];
   endproperty
   a_cca_sticky: assert property (p_cca_sticky)
      else $error("cca event not captured");

   property p_line_quiet;
      (s_q.stat == '0) |-> !irqLine1 && !irqLine2;
   endproperty
   a_line_quiet: assert property (p_line_quiet)
      else $error("interrupt line high with no flag set");

   property p_reserved_zero;
      s_q.l1SysEn[7:6] == 2'h0 && s_q.l2SysEn[0] == 1'b0
         && s_q.l1PktEn[7:5] == 3'h0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved enable bit stored");

endmodule

/* File: rtl/rpb_params.svh */
// register indices, field positions and reset values of the radio cfg bank
`ifndef RPB_PARAMS_SVH
`define RPB_PARAMS_SVH

// register indices; byte address is four times the index
`define RPB_IDX_EXT_AMP 10'h3AA
`define RPB_IDX_CONV_RBK 10'h3AE
`define RPB_IDX_GAIN_CFG5 10'h3B9
`define RPB_IDX_L1_SYS_EN 10'h3C7
`define RPB_IDX_L1_PKT_EN 10'h3C8
`define RPB_IDX_L2_SYS_EN 10'h3C9
`define RPB_IDX_L2_PKT_EN 10'h3CA
`define RPB_IDX_SYS_STAT 10'h3D0
`define RPB_IDX_PKT_STAT 10'h3D1
`define RPB_IDX_RSSI_RBK 10'h3D2

// field positions
`define RPB_LEVEL_LSB 4
`define RPB_BIAS_SRC_BIT 3
`define RPB_RSSI_OFFS_LSB 2
`define RPB_SYS_BATT 5
`define RPB_SYS_POR 4
`define RPB_SYS_CMD_ACCEPT 3
`define RPB_SYS_TIMER 2
`define RPB_SYS_READY 1
`define RPB_PKT_TX_DONE 4
`define RPB_PKT_RX_DONE 3
`define RPB_PKT_DELIM_TX 2
`define RPB_PKT_DELIM_RX 1
`define RPB_PKT_CCA 0

// writable bits of the enable registers
`define RPB_SYS_EN_MASK 8'h3E
`define RPB_PKT_EN_MASK 8'h1F

// reset values
`define RPB_RST_EXT_AMP 8'hF1
`define RPB_RST_GAIN_CFG5 8'h13
`define RPB_RST_SYS_EN 8'h02
`define RPB_RST_PKT_EN 8'h00

`endif

/* File: rtl/rpb_pkg.sv */
// types of the radio cfg bank
package rpb_pkg;

   // bias pin behaviour decoded from the interface mode field
   typedef enum logic [2:0] {
      RPB_BIAS_FLOAT = 3'h0,
      RPB_BIAS_SOURCE = 3'h1,
      RPB_BIAS_SINK = 3'h2,
      RPB_BIAS_SERVO_POS = 3'h3,
      RPB_BIAS_SERVO_NEG = 3'h4
   } rpb_bias_t;

   // bus answer phase, gray along idle -> answer
   typedef enum logic [1:0] {
      RPB_PH_IDLE = 2'h0,
      RPB_PH_ANSWER = 2'h1
   } rpb_phase_t;

   // event pulses of both groups, sys and pkt, one bit per source
   typedef struct packed {
      logic [7:0] sys;
      logic [7:0] pkt;
   } rpb_events_t;

   // amplifier controls seen by the analog side
   typedef struct packed {
      logic [3:0] level;
      logic bandgapRef;
      logic supplyOn;
      rpb_bias_t biasPin;
   } rpb_amp_t;

   typedef struct packed {
      rpb_phase_t phase;
      logic [31:0] prdata;
      logic pslverr;
      logic [7:0] extAmp;
      logic [7:0] gainCfg5;
      logic [7:0] l1SysEn;
      logic [7:0] l1PktEn;
      logic [7:0] l2SysEn;
      logic [7:0] l2PktEn;
      rpb_events_t stat;
      logic [7:0] rssiOut;
      rpb_amp_t amp;
      logic irq1;
      logic irq2;
   } rpb_state_t;

endpackage

/* File: tb/rpb_host_model.sv */
// host side model: counts assertions seen on both interrupt lines
`timescale 1ns/1ps
module rpb_host_model (
   // clock
   input wire logic clk,
   // interrupt lines from the bank
   input wire logic irqLine1,
   input wire logic irqLine2,
   // rising edges seen on each line
   output logic [7:0] irqCnt1,
   output logic [7:0] irqCnt2
);
   logic prev1 = 1'b0;
   logic prev2 = 1'b0;
   logic [7:0] cnt1 = 8'h00;
   logic [7:0] cnt2 = 8'h00;
   assign irqCnt1 = cnt1;
   assign irqCnt2 = cnt2;
   // lines are level: one count per assertion, not per cycle high
   always @(posedge clk) begin
      prev1 <= irqLine1;
      prev2 <= irqLine2;
      if (irqLine1 === 1'b1 && !prev1) cnt1 <= cnt1 + 8'h01;
      if (irqLine2 === 1'b1 && !prev2) cnt2 <= cnt2 + 8'h01;
   end
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the radio config register bank
`timescale 1ns/1ps
`include "rpb_params.svh"
module testbench;
   import rpb_pkg::*;
   logic clk, reset, psel, penable, pwrite, pready, pslverr;
   logic irqLine1, irqLine2;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   rpb_events_t events;
   rpb_amp_t amp;
   logic [5:0] convCode;
   logic [7:0] rssiRaw, rssiReported, irqCnt1, irqCnt2;
   int error_cnt = 0;
   int checks = 0;
   int cycles = 0;
   rpb_radio_bank rpb_radio_bank_inst (.clk(clk), .reset(reset),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .events(events), .convCode(convCode),
      .rssiRaw(rssiRaw), .amp(amp), .rssiReported(rssiReported),
      .irqLine1(irqLine1), .irqLine2(irqLine2));
   rpb_host_model rpb_host_model_inst (.clk(clk), .irqLine1(irqLine1),
      .irqLine2(irqLine2), .irqCnt1(irqCnt1), .irqCnt2(irqCnt2));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         error_cnt++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one apb transfer; a read compares its data, both compare the error
   task automatic apb(input logic w, input logic [9:0] idx,
         input logic [7:0] wd, input logic [31:0] exp, input logic eErr);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge clk);
      penable <= 1'b1;
      // only the bench timeout ends a wait for the slave
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      if (!w) chk(prdata, exp);
      chk({31'h0, pslverr}, {31'h0, eErr});
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic pulse(input logic [15:0] v);
      events <= v;
      @(posedge clk);
      events <= '0;
      repeat (2) @(posedge clk);
   endtask
   task automatic t_reset();
      logic [9:0] ix[6] = '{`RPB_IDX_EXT_AMP, `RPB_IDX_GAIN_CFG5,
         `RPB_IDX_L1_SYS_EN, `RPB_IDX_L2_SYS_EN, `RPB_IDX_L1_PKT_EN,
         `RPB_IDX_L2_PKT_EN};
      logic [7:0] ev[6] = '{8'hF1, 8'h13, 8'h02, 8'h02, 8'h00, 8'h00};
      chk(32'(amp), {23'h0, 4'hF, 1'b0, 1'b1, RPB_BIAS_SOURCE});
      for (int i = 0; i < 6; i++)
         apb(1'b0, ix[i], 8'h00, {24'h0, ev[i]}, 1'b0);
      pulse(16'h0200);
      chk({30'h0, irqLine1, irqLine2}, 32'h3);
      apb(1'b0, `RPB_IDX_SYS_STAT, 8'h00, 32'h02, 1'b0);
      chk({30'h0, irqLine1, irqLine2}, 32'h0);
      $display("t_reset done");
   endtask
   task automatic t_modes();
      rpb_bias_t b[8] = '{RPB_BIAS_FLOAT, RPB_BIAS_SOURCE, RPB_BIAS_SINK,
         RPB_BIAS_SOURCE, RPB_BIAS_SINK, RPB_BIAS_SERVO_POS,
         RPB_BIAS_SERVO_NEG, RPB_BIAS_FLOAT};
      logic [3:0] lv;
      logic [7:0] cfg;
      for (int m = 0; m < 8; m++) begin
         lv = (m == 0) ? 4'h3 : 4'(m + 8);
         cfg = {lv, m[0], m[2:0]};
         apb(1'b1, `RPB_IDX_EXT_AMP, cfg, 32'h0, 1'b0);
         apb(1'b0, `RPB_IDX_EXT_AMP, 8'h00, {24'h0, cfg}, 1'b0);
         chk(32'(amp), {23'h0, lv, m[0], !(m == 3 || m == 4), b[m]});
      end
      $display("t_modes done");
   endtask
   task automatic t_rssi();
      rssiRaw <= 8'h10;
      repeat (3) @(posedge clk);
      chk(32'(rssiReported), 32'h14);
      rssiRaw <= 8'hFE;
      apb(1'b1, `RPB_IDX_GAIN_CFG5, 8'h1F, 32'h0, 1'b0);
      repeat (2) @(posedge clk);
      chk(32'(rssiReported), 32'h05);
      apb(1'b0, `RPB_IDX_RSSI_RBK, 8'h00, 32'h05, 1'b0);
      $display("t_rssi done");
   endtask
   task automatic t_conv();
      convCode <= 6'h2A;
      @(posedge clk);
      apb(1'b0, `RPB_IDX_CONV_RBK, 8'h00, 32'h2A, 1'b0);
      apb(1'b1, `RPB_IDX_CONV_RBK, 8'hFF, 32'h0, 1'b0);
      convCode <= 6'h3F;
      apb(1'b0, `RPB_IDX_CONV_RBK, 8'h00, 32'h3F, 1'b0);
      apb(1'b0, 10'h000, 8'h00, 32'h0, 1'b1);
      $display("t_conv done");
   endtask
   task automatic t_irq();
      apb(1'b1, `RPB_IDX_L1_SYS_EN, 8'hFF, 32'h0, 1'b0);
      apb(1'b0, `RPB_IDX_L1_SYS_EN, 8'h00, 32'h3E, 1'b0);
      apb(1'b1, `RPB_IDX_L1_SYS_EN, 8'h08, 32'h0, 1'b0);
      apb(1'b1, `RPB_IDX_L2_SYS_EN, 8'h00, 32'h0, 1'b0);
      apb(1'b1, `RPB_IDX_L1_PKT_EN, 8'h1F, 32'h0, 1'b0);
      apb(1'b1, `RPB_IDX_L2_PKT_EN, 8'h08, 32'h0, 1'b0);
      pulse(16'h0800);
      chk({30'h0, irqLine1, irqLine2}, 32'h2);
      apb(1'b0, `RPB_IDX_SYS_STAT, 8'h00, 32'h08, 1'b0);
      chk({31'h0, irqLine1}, 32'h0);
      for (int b = 0; b < 5; b++) begin
         pulse(16'(1 << b));
         chk({30'h0, irqLine1, irqLine2}, {30'h0, 1'b1, b == 3});
         apb(1'b0, `RPB_IDX_PKT_STAT, 8'h00, 32'(1 << b), 1'b0);
         chk({30'h0, irqLine1, irqLine2}, 32'h0);
      end
      chk({16'h0, irqCnt1, irqCnt2}, 32'h0702);
      $display("t_irq done");
   endtask
   initial begin
      reset = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      events = '0;
      convCode = 6'h00;
      rssiRaw = 8'h00;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      t_reset();
      t_modes();
      t_rssi();
      t_conv();
      t_irq();
      print_verdict();
   end
endmodule
